// [design/odrc_pkg.sv]
package odrc_pkg;
    // clock and timing
    localparam int          CLK_MHZ        = 50;
    localparam int          FRC_RST_NS     = 1000;
    localparam int          FRC_RST_CYC    = (FRC_RST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [5:0]  FRC_RST_LOAD   = 6'(FRC_RST_CYC);
    // serial frame: 8-bit opcode then 32-bit argument, msb first
    localparam logic [5:0]  FRAME_LAST     = 6'h27;
    // security code in flash, byte at 0x70 sits in bits 7:0
    localparam int          ID_BYTES       = 10;
    localparam logic [31:0] ID_FIRST_ADDR  = 32'h0000_0070;
    localparam logic [31:0] ID_LAST_ADDR   = 32'h0000_0079;
    localparam int          ID_ENABLE_BIT  = 79;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;
    localparam logic [31:0] ILLEGAL_VEC    = 32'h0000_0060;
    localparam logic [31:0] ROM_END_ADDR   = 32'h0004_0000;
    // breakpoints: entries 0..1 hardware, 2..5 software
    localparam int          HW_BP_NUM      = 2;
    localparam int          BP_NUM         = 6;
    // link opcodes
    localparam logic [7:0]  OP_ID_BYTE     = 8'h01;
    localparam logic [7:0]  OP_ID_CHECK    = 8'h02;
    localparam logic [7:0]  OP_BREAK       = 8'h10;
    localparam logic [7:0]  OP_RESUME      = 8'h11;
    localparam logic [7:0]  OP_FRC_RESET   = 8'h12;
    localparam logic [7:0]  OP_BRK_RESET   = 8'h13;
    localparam logic [7:0]  OP_BP_CTRL     = 8'h1f;
    localparam logic [7:0]  OP_BP_ADDR0    = 8'h20;
    localparam logic [7:0]  OP_MASK        = 8'h30;
    localparam logic [7:0]  OP_MEM_ADDR    = 8'h40;
    localparam logic [7:0]  OP_MEM_RD      = 8'h41;
    localparam logic [7:0]  OP_MEM_WR      = 8'h42;
    localparam logic [7:0]  OP_MEM_DATA    = 8'h43;
    localparam logic [7:0]  OP_TIMER_RD    = 8'h50;
    localparam logic [7:0]  OP_TIMER_CLR   = 8'h51;
    localparam logic [7:0]  OP_STATUS      = 8'h52;
    // software register port
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h1;
    localparam logic [3:0]  REG_TIMER      = 4'h2;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_BRK = 3'b010,
        ST_RST = 3'b100
    } odrc_state_type;

    typedef struct packed {
        logic [7:0]  op;
        logic [31:0] arg;
    } odrc_frame_type;

    typedef struct packed {
        logic [26:0] zero;
        logic        unit_on;
        logic        core_rst;
        logic        armed;
        logic        in_break;
        logic        unlocked;
    } odrc_status_type;
endpackage : odrc_pkg

// [design/odrc_run_control.sv]
// How it works
// - debug reset low gives port pins to port logic; high gives them to debug.
// - only reset, clock, mode, data in and data out; no boundary scan.
// - ten entered code bytes must match flash code before debugging is allowed.
// - flag bit 7 of last code byte clear refuses debugging despite match.
// - erased flash gives an all-0xff code, compared like any other.
// - two shared breakpoints, each on fetch or on data access.
// - four software breakpoints on fetches inside internal ROM.
// - emulator break halts user code; illegal-opcode vector belongs to monitor.
// - emulator can force a full device reset.
// - break-reset enters debug mode on reset release, before any instruction.
// - halted core uses debug space; user memory access; resume anywhere.
// - one mask hides watchdog irq, another hides pin and watchdog resets.
// - external reset always resets port buffers, even when masked.
// - external reset is ignored while in a break.
// - watchdog and clock monitor stop in break; selected group stops together.
// - open-break puts chosen timer outputs in high impedance during break.
// - timer measures user program run time.
// - clocks and pll keep running while debug is active.
// - reset during run may upset breaking; no guarantee afterwards.
// - rom correction is not emulated.
`timescale 1ns/1ps
module odrc_run_control import odrc_pkg::*; (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        DEBUG_UNIT_RESET_N,
    input  wire logic        EXT_RESET_N,
    input  wire logic [2:0]  PORT5_PIN_IN,
    output logic [2:0]       PORT5_PIN_OUT,
    output logic [2:0]       PORT5_PIN_OE,
    output logic             DEBUG_SERIAL_OUT,
    input  wire logic [2:0]  PORT5_GPIO_OUT,
    input  wire logic [2:0]  PORT5_GPIO_OE,
    output logic [2:0]       PORT5_GPIO_IN,
    input  wire logic [79:0] FLASH_ID_CODE,
    input  wire logic        FETCH_VALID,
    input  wire logic [31:0] FETCH_ADDR,
    input  wire logic        DATA_VALID,
    input  wire logic [31:0] DATA_ADDR,
    input  wire logic        SW_BREAK_TRAP,
    input  wire logic        WDT_IRQ_IN,
    input  wire logic        WDT_RESET_IN,
    output logic             CORE_RESET,
    output logic             PORT_BUF_RESET,
    output logic             WDT_IRQ_OUT,
    output logic             CPU_HALT,
    output logic             RESUME_START,
    output logic [31:0]      RESUME_PC,
    output logic             ILLEGAL_TRAP_RESERVED,
    output logic             WDT_CLKMON_STOP,
    output logic             PERIPH_GROUP_STOP,
    output logic [3:0]       TIMER_OUT_HIZ,
    output logic             CLOCK_KEEP_RUNNING,
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic [31:0]      MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic [31:0] MEM_RDATA,
    input  wire logic        MEM_ACK,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA
);
    logic [4:0]      pin_s1_q, pin_s2_q;
    logic            debug_unit_reset_n, debug_link_clock;
    logic            debug_transfer_mode_select, debug_serial_in;
    logic            ext_rst, dbg_rst, ck_prev_q, ck_rise, frame_done_q;
    logic [5:0]      bit_cnt_q, rst_cnt_q;
    logic [39:0]     rx_q;
    logic [31:0]     tx_q, rsp_d, timer_q, mem_rdata_q, rdata_q;
    odrc_frame_type  frame;
    logic [79:0]     id_entry_q;
    logic            unlocked_q, act_cmd, armed_q, irq_mask_q, rst_mask_q;
    logic [11:0]     bp_ctl_q;
    logic [31:0]     bp_addr_q [BP_NUM];
    logic [BP_NUM-1:0] bp_hit;
    logic            brk_req, frc_cmd, rst_src;
    odrc_state_type  st_q;
    odrc_status_type status;
    logic [7:0]      ctrl_q;
    logic            core_rst_q, port_rst_q, irq_q, start_q, mreq_q, mwe_q;
    logic [31:0]     pc_q, maddr_q, mwdata_q;
    logic [2:0]      pout_q, poe_q;
    logic            in_break;

    // pins and external reset pass two flops before use
    always_ff @(posedge CLK) begin
        if (RST) begin
            // reset pin idles high: no false reset pulse after RST
            pin_s1_q <= 5'h10;
            pin_s2_q <= 5'h10;
        end else begin
            pin_s1_q <= {EXT_RESET_N, DEBUG_UNIT_RESET_N, PORT5_PIN_IN};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign debug_serial_in            = pin_s2_q[0];
    assign debug_link_clock           = pin_s2_q[1];
    assign debug_transfer_mode_select = pin_s2_q[2];
    assign debug_unit_reset_n         = pin_s2_q[3];
    assign ext_rst                    = ~pin_s2_q[4];
    assign dbg_rst                    = RST | ~debug_unit_reset_n;
    assign in_break                   = (st_q == ST_BRK);

    // pin ownership; encoder timer cut off while debug owns pins
    always_ff @(posedge CLK) begin
        if (RST) begin
            pout_q <= 3'h0;
            poe_q  <= 3'h0;
        end else begin
            pout_q <= debug_unit_reset_n ? 3'h0 : PORT5_GPIO_OUT;
            poe_q  <= debug_unit_reset_n ? 3'h0 : PORT5_GPIO_OE;
        end
    end
    assign PORT5_PIN_OUT = pout_q;
    assign PORT5_PIN_OE  = poe_q;
    assign PORT5_GPIO_IN = debug_unit_reset_n ? 3'h0 : pin_s2_q[2:0];

    // serial link, shifts on link clock rising edges found by CLK
    assign ck_rise = debug_link_clock & ~ck_prev_q;
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            ck_prev_q    <= 1'b0;
            bit_cnt_q    <= 6'h00;
            rx_q         <= 40'h00_0000_0000;
            frame_done_q <= 1'b0;
        end else begin
            ck_prev_q    <= debug_link_clock;
            frame_done_q <= 1'b0;
            if (ck_rise && !debug_transfer_mode_select) begin
                bit_cnt_q <= 6'h00;
            end else if (ck_rise) begin
                rx_q <= {rx_q[38:0], debug_serial_in};
                if (bit_cnt_q == FRAME_LAST) begin
                    bit_cnt_q    <= 6'h00;
                    frame_done_q <= 1'b1;
                end else begin
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                end
            end
        end
    end
    assign frame   = rx_q;
    assign act_cmd = frame_done_q & unlocked_q;

    always_comb begin
        rsp_d = 32'h0000_0000;
        case (frame.op)
            OP_TIMER_RD: rsp_d = timer_q;
            OP_MEM_DATA: rsp_d = mem_rdata_q;
            OP_STATUS:   rsp_d = status;
            default:     rsp_d = 32'h0000_0000;
        endcase
    end

    // answer word is loaded at frame end and shifted out in the next frame
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            tx_q <= 32'h0000_0000;
        end else if (frame_done_q) begin
            tx_q <= rsp_d;
        end else if (ck_rise && debug_transfer_mode_select) begin
            tx_q <= {tx_q[30:0], 1'b0};
        end
    end
    assign DEBUG_SERIAL_OUT = tx_q[31];

    // compare entered code with flash; erased part compares as all 0xff
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            id_entry_q <= 80'h0;
            unlocked_q <= 1'b0;
        end else if (frame_done_q && frame.op == OP_ID_BYTE) begin
            id_entry_q <= {frame.arg[7:0], id_entry_q[79:8]};
        end else if (frame_done_q && frame.op == OP_ID_CHECK) begin
            unlocked_q <= (id_entry_q == FLASH_ID_CODE) && FLASH_ID_CODE[ID_ENABLE_BIT];
        end
    end

    // debug configuration written over the link
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            bp_ctl_q   <= 12'h000;
            irq_mask_q <= 1'b0;
            rst_mask_q <= 1'b0;
        end else if (act_cmd && frame.op == OP_BP_CTRL) begin
            bp_ctl_q <= frame.arg[11:0];
        end else if (act_cmd && frame.op == OP_MASK) begin
            irq_mask_q <= frame.arg[0];
            rst_mask_q <= frame.arg[1];
        end
    end

    // entries 0..1 fetch or data; entries 2..5 rom fetch only
    genvar gi;
    generate
        for (gi = 0; gi < BP_NUM; gi++) begin : g_bp
            always_ff @(posedge CLK) begin
                if (dbg_rst) begin
                    bp_addr_q[gi] <= 32'h0000_0000;
                end else if (act_cmd && frame.op == OP_BP_ADDR0 + 8'(gi)) begin
                    bp_addr_q[gi] <= frame.arg;
                end
            end
            if (gi < HW_BP_NUM) begin : g_hw
                assign bp_hit[gi] = bp_ctl_q[2*gi] & (bp_ctl_q[2*gi+1]
                    ? DATA_VALID & (DATA_ADDR == bp_addr_q[gi])
                    : FETCH_VALID & (FETCH_ADDR == bp_addr_q[gi]));
            end else begin : g_sw
                assign bp_hit[gi] = bp_ctl_q[2*gi] & FETCH_VALID
                    & (FETCH_ADDR < ROM_END_ADDR) & (FETCH_ADDR == bp_addr_q[gi]);
            end
        end
    endgenerate

    // forced break; software trap covers ram breakpoints set by the debugger
    assign brk_req = unlocked_q & ((act_cmd && frame.op == OP_BREAK) | (|bp_hit)
                     | SW_BREAK_TRAP);
    assign frc_cmd = act_cmd && (frame.op == OP_FRC_RESET || frame.op == OP_BRK_RESET);
    // reset mask hides pin and watchdog resets
    assign rst_src = (ext_rst | WDT_RESET_IN) & ~rst_mask_q;

    // a reset while running just restarts; breaking state is not kept
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            st_q      <= ST_RUN;
            rst_cnt_q <= 6'h00;
        end else begin
            case (st_q)
                ST_RUN: begin
                    if (frc_cmd || rst_src) begin
                        st_q      <= ST_RST;
                        rst_cnt_q <= FRC_RST_LOAD;
                    end else if (brk_req) begin
                        st_q <= ST_BRK;
                    end
                end
                // stays halted until resume or a forced or break reset; pin reset ignored here
                ST_BRK: begin
                    if (frc_cmd) begin
                        st_q      <= ST_RST;
                        rst_cnt_q <= FRC_RST_LOAD;
                    end else if (act_cmd && frame.op == OP_RESUME) begin
                        st_q <= ST_RUN;
                    end
                end
                // reset held a fixed count, reloaded while a pin or watchdog reset is present; armed release halts
                ST_RST: begin
                    if (rst_src) begin
                        rst_cnt_q <= FRC_RST_LOAD;
                    end else if (rst_cnt_q == 6'h00) begin
                        st_q <= armed_q ? ST_BRK : ST_RUN;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 6'h01;
                    end
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            armed_q <= 1'b0;
        end else if (act_cmd && frame.op == OP_BRK_RESET) begin
            armed_q <= 1'b1;
        end else if (st_q == ST_RST && !rst_src && rst_cnt_q == 6'h00) begin
            armed_q <= 1'b0;
        end
    end

    // port buffers follow the pin reset regardless of masks
    always_ff @(posedge CLK) begin
        if (RST) begin
            core_rst_q <= 1'b0;
            port_rst_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            core_rst_q <= unlocked_q ? (st_q == ST_RST) : (ext_rst | WDT_RESET_IN);
            port_rst_q <= ext_rst | core_rst_q;
            irq_q      <= WDT_IRQ_IN & ~(unlocked_q & irq_mask_q);
        end
    end

    // run-time counter; counts only while user code runs
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            timer_q <= 32'h0000_0000;
        end else if (act_cmd && frame.op == OP_TIMER_CLR) begin
            timer_q <= 32'h0000_0000;
        end else if (st_q == ST_RUN) begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end

    // user memory access only while halted; resume from any address
    always_ff @(posedge CLK) begin
        if (dbg_rst) begin
            start_q     <= 1'b0;
            pc_q        <= 32'h0000_0000;
            mreq_q      <= 1'b0;
            mwe_q       <= 1'b0;
            maddr_q     <= 32'h0000_0000;
            mwdata_q    <= 32'h0000_0000;
            mem_rdata_q <= 32'h0000_0000;
        end else begin
            start_q <= in_break && act_cmd && frame.op == OP_RESUME;
            mreq_q  <= in_break && act_cmd && (frame.op == OP_MEM_RD || frame.op == OP_MEM_WR);
            if (in_break && act_cmd && frame.op == OP_RESUME) begin
                pc_q <= frame.arg;
            end
            if (act_cmd && frame.op == OP_MEM_ADDR) begin
                maddr_q <= frame.arg;
            end
            if (in_break && act_cmd && frame.op == OP_MEM_RD) begin
                mwe_q <= 1'b0;
            end else if (in_break && act_cmd && frame.op == OP_MEM_WR) begin
                mwe_q    <= 1'b1;
                mwdata_q <= frame.arg;
            end
            if (MEM_ACK && !mwe_q) begin
                mem_rdata_q <= MEM_RDATA;
            end
        end
    end

    // software register port, read data one cycle later
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q  <= CTRL_RESET;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (REG_WR && REG_ADDR == REG_CTRL) begin
                ctrl_q <= REG_WDATA[7:0];
            end
            if (!REG_RD) begin
                rdata_q <= 32'h0000_0000;
            end else if (REG_ADDR == REG_CTRL) begin
                rdata_q <= {24'h00_0000, ctrl_q};
            end else if (REG_ADDR == REG_STATUS) begin
                rdata_q <= status;
            end else if (REG_ADDR == REG_TIMER) begin
                rdata_q <= timer_q;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    always_comb begin
        status          = '0;
        status.unlocked = unlocked_q;
        status.in_break = in_break;
        status.armed    = armed_q;
        status.core_rst = core_rst_q;
        status.unit_on  = debug_unit_reset_n;
    end

    // no rom correction path exists in this unit
    assign CORE_RESET            = core_rst_q;
    assign PORT_BUF_RESET        = port_rst_q;
    assign WDT_IRQ_OUT           = irq_q;
    assign CPU_HALT              = in_break;
    assign RESUME_START          = start_q;
    assign RESUME_PC             = pc_q;
    assign ILLEGAL_TRAP_RESERVED = unlocked_q;
    assign WDT_CLKMON_STOP       = in_break;
    assign PERIPH_GROUP_STOP     = in_break & ctrl_q[0];
    assign TIMER_OUT_HIZ         = in_break ? ctrl_q[7:4] : 4'h0;
    assign CLOCK_KEEP_RUNNING    = unlocked_q;
    assign MEM_REQ               = mreq_q;
    assign MEM_WE                = mwe_q;
    assign MEM_ADDR              = maddr_q;
    assign MEM_WDATA             = mwdata_q;
    assign REG_RDATA             = rdata_q;

    a_pin_handover: assert property (@(posedge CLK) disable iff (RST)
        debug_unit_reset_n |=> PORT5_PIN_OE == 3'h0)
        else $error("port pins driven while debug owns them");
    a_id_match: assert property (@(posedge CLK) disable iff (dbg_rst)
        frame_done_q && frame.op == OP_ID_CHECK && id_entry_q == FLASH_ID_CODE
        && FLASH_ID_CODE[ID_ENABLE_BIT] |=> unlocked_q)
        else $error("matching code did not unlock");
    a_flag_refuse: assert property (@(posedge CLK) disable iff (dbg_rst)
        frame_done_q && frame.op == OP_ID_CHECK && !FLASH_ID_CODE[ID_ENABLE_BIT]
        |=> !unlocked_q ##1 !CLOCK_KEEP_RUNNING)
        else $error("cleared enable flag still unlocked");
    a_hw_break: assert property (@(posedge CLK) disable iff (dbg_rst)
        st_q == ST_RUN && unlocked_q && |bp_hit[1:0] && !frc_cmd && !rst_src
        |=> st_q == ST_BRK ##1 CPU_HALT)
        else $error("breakpoint hit did not halt");
    a_break_hold: assert property (@(posedge CLK) disable iff (dbg_rst)
        in_break && !frc_cmd && !(act_cmd && frame.op == OP_RESUME) |=> in_break)
        else $error("break left without resume");
    a_forced_reset: assert property (@(posedge CLK) disable iff (dbg_rst)
        st_q != ST_RST && frc_cmd |=> st_q == ST_RST ##1 CORE_RESET)
        else $error("forced reset not applied");
    a_break_reset: assert property (@(posedge CLK) disable iff (dbg_rst)
        st_q == ST_RST && armed_q && !rst_src && rst_cnt_q == 6'h00
        |=> in_break && !armed_q)
        else $error("break-reset did not enter break");
    a_port_reset: assert property (@(posedge CLK) disable iff (RST)
        ext_rst ##1 ext_rst |=> PORT_BUF_RESET)
        else $error("port buffers missed pin reset");
    a_run_timer: assert property (@(posedge CLK) disable iff (dbg_rst)
        st_q == ST_RUN && !(act_cmd && frame.op == OP_TIMER_CLR)
        |=> timer_q == $past(timer_q) + 32'h0000_0001)
        else $error("run timer did not advance");
    a_group_stop: assert property (@(posedge CLK) disable iff (RST)
        in_break |-> WDT_CLKMON_STOP && PERIPH_GROUP_STOP == ctrl_q[0])
        else $error("break stop group wrong");
endmodule : odrc_run_control

// [dv/odrc_emu_model.sv]
`timescale 1ns/1ps
module odrc_emu_model (
    output logic       debug_unit_reset_n,
    output logic [2:0] pin_in,
    input  wire logic  serial_out
);
    logic [39:0] ans;
    initial begin
        debug_unit_reset_n = 1'b0;
        pin_in = 3'h0;
        ans = '0;
    end
    task automatic send(input logic [7:0] op, input logic [31:0] arg);
        logic [39:0] f;
        f = {op, arg};
        // step off the system clock edge so the syncs see settled levels
        #5 pin_in[2] = 1'b1;
        for (int i = 0; i < 40; i++) begin
            pin_in[0] = f[39-i];
            #80 ans = {ans[38:0], serial_out};
            pin_in[1] = 1'b1;
            #80 pin_in[1] = 1'b0;
        end
        // clock parks low; no pull on data, so show the inverse
        pin_in[0] = ~pin_in[0];
        pin_in[2] = 1'b0;
        #160;
    endtask : send
endmodule : odrc_emu_model

// [dv/odrc_run_control_tb_top.sv]
`timescale 1ns/1ps
module odrc_run_control_tb_top import odrc_pkg::*;;
    logic        clk, rst, debug_unit_reset_n_n, ext_n, dout, fv, dv, sw, wirq, wrst, mack, wr, rd, rd_q;
    logic        core_rst, pbuf, wirq_o, halt, ill, wstop, gstop, clkrun;
    logic [2:0]  pin_in, pin_out, pin_oe, g_out, g_oe, g_in;
    logic [79:0] flash;
    logic [31:0] fa, da, mrd, wd, rdata, rpc, a, maddr;
    logic [31:0] lfsr = 32'h0001_1aa2;
    logic [7:0]  ctl;
    logic [3:0]  ra, hiz;
    int          fails, comparisons;
    int          cyc = 0;
    logic [31:0] q[$];
    odrc_run_control odrc_run_control_i (
        .CLK(clk), .RST(rst), .DEBUG_UNIT_RESET_N(debug_unit_reset_n_n), .EXT_RESET_N(ext_n),
        .PORT5_PIN_IN(pin_in), .PORT5_PIN_OUT(pin_out), .PORT5_PIN_OE(pin_oe),
        .DEBUG_SERIAL_OUT(dout), .PORT5_GPIO_OUT(g_out), .PORT5_GPIO_OE(g_oe),
        .PORT5_GPIO_IN(g_in), .FLASH_ID_CODE(flash), .FETCH_VALID(fv), .FETCH_ADDR(fa),
        .DATA_VALID(dv), .DATA_ADDR(da), .SW_BREAK_TRAP(sw), .WDT_IRQ_IN(wirq),
        .WDT_RESET_IN(wrst), .CORE_RESET(core_rst), .PORT_BUF_RESET(pbuf),
        .WDT_IRQ_OUT(wirq_o), .CPU_HALT(halt), .RESUME_START(), .RESUME_PC(rpc),
        .ILLEGAL_TRAP_RESERVED(ill), .WDT_CLKMON_STOP(wstop), .PERIPH_GROUP_STOP(gstop),
        .TIMER_OUT_HIZ(hiz), .CLOCK_KEEP_RUNNING(clkrun), .MEM_REQ(), .MEM_WE(),
        .MEM_ADDR(maddr), .MEM_WDATA(), .MEM_RDATA(mrd), .MEM_ACK(mack), .REG_ADDR(ra),
        .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
    odrc_emu_model odrc_emu_model_i (
        .debug_unit_reset_n(debug_unit_reset_n_n), .pin_in(pin_in), .serial_out(dout));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic wait_c(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_c
    // read notes its expected word; a write carries the data
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] d);
        @(posedge clk);
        ra <= adr;
        wd <= d;
        wr <= we;
        rd <= !we;
        if (!we) q.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic link(input logic [7:0] op, input logic [31:0] arg);
        odrc_emu_model_i.send(op, arg);
        wait_c(12);
    endtask : link
    task automatic unlock();
        for (int i = 0; i < ID_BYTES; i++) link(OP_ID_BYTE, {24'h0, flash[8*i +: 8]});
        link(OP_ID_CHECK, 32'h0);
    endtask : unlock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        lfsr <= nxt(lfsr);
        mrd <= lfsr;
        rd_q <= rd;
        cyc <= cyc + 1;
        if (rd_q) check("reg read", rdata, q.pop_front());
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {rst, ext_n, fv, dv, sw, wirq, wrst, mack, wr, rd} = 10'b1100000000;
        {fa, da, wd, ra, g_out, g_oe} = '0;
        flash = '1;
        flash[ID_ENABLE_BIT] = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        g_out <= lfsr[2:0];
        g_oe <= lfsr[5:3];
        ctl = lfsr[15:8];
        wait_c(4);
        check("pin out", pin_out, g_out);
        check("pin oe", pin_oe, g_oe);
        check("gpio in", g_in, pin_in);
        bus(1'b1, REG_CTRL, {24'h0, ctl});
        bus(1'b0, REG_CTRL, {24'h0, ctl});
        bus(1'b1, REG_STATUS, 32'hffff_ffff);
        bus(1'b0, REG_STATUS, 32'h0);
        bus(1'b0, 4'hf, 32'h0);
        odrc_emu_model_i.debug_unit_reset_n <= 1'b1;
        wait_c(6);
        check("pin oe dbg", pin_oe, 3'h0);
        check("gpio in dbg", g_in, 3'h0);
        link(OP_BREAK, 32'h0);
        check("locked halt", halt, 1'b0);
        unlock();
        bus(1'b0, REG_STATUS, 32'h10);
        flash = '1;
        unlock();
        bus(1'b0, REG_STATUS, 32'h11);
        check("clock keep", clkrun, 1'b1);
        check("trap vec", ill, 1'b1);
        link(OP_BREAK, 32'h0);
        wait_c(300);
        check("halt held", halt, 1'b1);
        bus(1'b0, REG_STATUS, 32'h13);
        check("wdt stop", wstop, 1'b1);
        check("group stop", gstop, ctl[0]);
        check("open break", hiz, ctl[7:4]);
        link(OP_STATUS, 32'h0);
        link(OP_STATUS, 32'h0);
        check("link answer", odrc_emu_model_i.ans[39:8], 32'h13);
        ext_n <= 1'b0;
        wait_c(8);
        check("core rst brk", core_rst, 1'b0);
        check("port buf rst", pbuf, 1'b1);
        ext_n <= 1'b1;
        wait_c(8);
        a = lfsr;
        link(OP_RESUME, a);
        check("resume pc", rpc, a);
        check("running", halt, 1'b0);
        wirq <= 1'b1;
        wait_c(4);
        check("wdt irq", wirq_o, 1'b1);
        link(OP_MASK, 32'h1);
        check("wdt irq mask", wirq_o, 1'b0);
        wirq <= 1'b0;
        link(OP_BP_ADDR0, a);
        link(OP_BP_CTRL, 32'h1);
        fv <= 1'b1;
        fa <= a;
        @(posedge clk);
        fv <= 1'b0;
        wait_c(4);
        check("fetch bp", halt, 1'b1);
        link(OP_FRC_RESET, 32'h0);
        check("forced rst", core_rst, 1'b1);
        link(OP_BRK_RESET, 32'h0);
        wait_c(60);
        check("break reset", halt, 1'b1);
        bus(1'b0, REG_STATUS, 32'h13);
        link(OP_TIMER_CLR, 32'h0);
        bus(1'b0, REG_TIMER, 32'h0);
        link(OP_MEM_ADDR, a);
        check("mem addr", maddr, a);
        link(OP_MEM_RD, 32'h0);
        mack <= 1'b1;
        @(posedge clk);
        a = mrd;
        mack <= 1'b0;
        link(OP_MEM_DATA, 32'h0);
        link(OP_MEM_DATA, 32'h0);
        check("mem read", odrc_emu_model_i.ans[39:8], a);
        stop_test();
    end
endmodule : odrc_run_control_tb_top
